//--- verilog/sensor_regs_pkg.sv
// shared constants for the sensor command and result register bank
`default_nettype none
package sensor_regs_pkg;
    // i2c addressing
    localparam logic [6:0] SLAVE_BASE     = 7'h36;     // upper six bits of 0x6c/0x6d
    // register byte addresses
    localparam logic [7:0] ADDR_CMD       = 8'h22;
    localparam logic [7:0] ADDR_TEMP      = 8'h2E;
    localparam logic [7:0] ADDR_PRES      = 8'h30;
    localparam logic [7:0] ADDR_SYNC      = 8'h32;
    localparam logic [7:0] ADDR_STATUS    = 8'h36;
    // command codes
    localparam logic [15:0] CMD_SLEEP     = 16'h6C32;
    localparam logic [15:0] CMD_RESET     = 16'hB169;
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
    // status bit positions
    localparam int BIT_IDLE     = 0;
    localparam int BIT_S_UP     = 3;
    localparam int BIT_T_UP     = 4;
    localparam int BIT_CRC_ERR  = 11;
    localparam int BIT_S_MISSED = 14;
    localparam int BIT_T_MISSED = 15;
    localparam logic [15:0] EVENT_MASK    = 16'hCB9E;   // event type bits
    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    // frame check seeds and polynomials
    localparam logic [3:0] CRC4_POLY      = 4'h3;
    localparam logic [3:0] CRC4_INIT      = 4'hF;
    localparam logic [7:0] CRC8_POLY      = 8'hD5;
    localparam logic [7:0] CRC8_INIT      = 8'hFF;
    localparam logic [3:0] MAX_CRC_LEN    = 4'h3;       // four data bytes minus one
    // reset sequence length in system clocks
    localparam int RELOAD_CYCLES          = 16;
endpackage
`default_nettype wire

//--- verilog/frame_crc.sv
// bitwise crc of one byte, msb first, width as a parameter and polynomial as an input
`default_nettype none
module frame_crc #(
    parameter int W = 8
) (
    // running value and byte
    input  wire logic [W-1:0] i_crc,
    input  wire logic [W-1:0] i_poly,
    input  wire logic [7:0]   i_byte,
    // next value
    output logic [W-1:0]      o_crc
);
    // one shift per data bit, transmission order
    always_comb
    begin
        o_crc = i_crc;
        for (int b = 7; b >= 0; b--)
        begin
            if (o_crc[W-1] ^ i_byte[b])
                o_crc = {o_crc[W-2:0], 1'b0} ^ i_poly;
            else
                o_crc = {o_crc[W-2:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

//--- verilog/sensor_command_result_regs.sv
// i2c write side, command decode, result and status registers of the sensor
// How it works
// - sleep code in command enters sleep
// - reset code reruns reload and memory check
// - only status and command are writable
// - temperature result load sets its flag
// - pressure result load sets its flag
// - results invalid until both a temperature and a pressure result loaded
// - failed memory check blocks result updates
// - protected write adds length/crc4 and crc8
// - status word write clears selected flags
// - two command bytes form one word
// - length nibble is data bytes minus one
// - crc4 poly 0x03 seed 0x0f
// - crc8 poly 0xd5 seed 0xff, error flag
// - flags stay until one written or a reset command
`default_nettype none
module sensor_command_result_regs (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // i2c pins, open drain data
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_oe,
    // measurement path
    input  wire logic        i_temp_load,
    input  wire logic [15:0] i_temp_value,
    input  wire logic        i_pres_load,
    input  wire logic [15:0] i_pres_value,
    input  wire logic        i_crc_ok,
    input  wire logic        i_reload_done,
    input  wire logic        i_idle,
    // device state
    output logic             o_sleep,
    output logic             o_reload,
    output logic             o_results_valid,
    output logic [15:0]      o_temp,
    output logic [15:0]      o_pres,
    output logic [15:0]      o_status
);
    typedef enum {S_IDLE, S_DEV, S_MADDR, S_LEN, S_DATA, S_IGNORE} frame_e;

    // pin synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    // bus events from the synchronised pins
    wire scl_rise = scl_sync[1] & ~scl_q;
    wire scl_fall = ~scl_sync[1] & scl_q;
    wire start_ev = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    wire stop_ev  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

    // byte shifter and frame state
    frame_e     state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic       ack_phase;
    logic       crc_mode;
    logic [7:0] maddr;
    logic [3:0] len;
    logic [2:0] dcnt;
    logic [7:0] lo_byte;
    logic [15:0] word;
    logic [3:0] crc4;
    logic [7:0] crc8;
    logic       word_pend;
    logic [7:0] word_addr;

    wire [7:0] rx_byte   = {shreg[6:0], sda_q};
    wire       byte_done = scl_rise & ~ack_phase & (bitcnt == 4'd7);
    wire [3:0] crc4_next;
    wire [7:0] crc8_next;

    // crc4 runs over the memory address byte and the length nibble
    frame_crc #(.W(4)) u_crc4 (
        .i_crc  (crc4),
        .i_poly (sensor_regs_pkg::CRC4_POLY),
        .i_byte (rx_byte),
        .o_crc  (crc4_next)
    );
    // crc8 covers the data bytes
    frame_crc #(.W(8)) u_crc8 (
        .i_crc  (crc8),
        .i_poly (sensor_regs_pkg::CRC8_POLY),
        .i_byte (rx_byte),
        .o_crc  (crc8_next)
    );

    // crc4 over maddr and the length nibble; the device byte stays out of it
    logic [3:0] crc4_hi;
    always_comb
    begin
        crc4_hi = crc4;
        for (int b = 7; b >= 4; b--)
        begin
            if (crc4_hi[3] ^ rx_byte[b])
                crc4_hi = {crc4_hi[2:0], 1'b0} ^ sensor_regs_pkg::CRC4_POLY;
            else
                crc4_hi = {crc4_hi[2:0], 1'b0};
        end
    end

    wire dev_match = (rx_byte[7:2] == sensor_regs_pkg::SLAVE_BASE[5:0]) & ~rx_byte[0];
    wire len_ok    = (rx_byte[7:4] <= sensor_regs_pkg::MAX_CRC_LEN) & rx_byte[4]
                   & (crc4_hi == rx_byte[3:0]);
    wire crc_byte  = crc_mode & (state == S_DATA) & ({1'b0, dcnt} == len + 4'd1);
    wire odd_data  = (state == S_DATA) & ~crc_byte & dcnt[0];
    wire crc4_bad  = (state == S_LEN) & (crc4_hi != rx_byte[3:0]);
    wire ev_crc    = byte_done & ((crc_byte & (rx_byte != crc8)) | crc4_bad);

    // frame decoder: acks only bytes that belong to a write frame
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state     <= S_IDLE;
            shreg     <= 8'h00;
            bitcnt    <= 4'h0;
            ack_phase <= 1'b0;
            crc_mode  <= 1'b0;
            maddr     <= 8'h00;
            len       <= 4'h0;
            dcnt      <= 3'h0;
            lo_byte   <= 8'h00;
            crc4      <= sensor_regs_pkg::CRC4_INIT;
            crc8      <= sensor_regs_pkg::CRC8_INIT;
            o_sda_oe  <= 1'b0;
            word_pend <= 1'b0;
            word      <= 16'h0000;
            word_addr <= 8'h00;
        end
        else if (start_ev | stop_ev)
        begin
            state     <= start_ev ? S_DEV : S_IDLE;
            bitcnt    <= 4'h0;
            ack_phase <= 1'b0;
            o_sda_oe  <= 1'b0;
            crc4      <= sensor_regs_pkg::CRC4_INIT;
            crc8      <= sensor_regs_pkg::CRC8_INIT;
            dcnt      <= 3'h0;
            word_pend <= 1'b0;
        end
        else
        begin
            word_pend <= 1'b0;
            if (scl_rise & ~ack_phase)
            begin
                shreg  <= rx_byte;
                bitcnt <= bitcnt + 4'd1;
            end
            if (byte_done)
            begin
                bitcnt    <= 4'h0;
                ack_phase <= 1'b1;
                case (state)
                    S_DEV:
                    begin
                        crc_mode <= rx_byte[1];
                        // device byte leaves crc4 at its seed
                        state    <= dev_match ? S_MADDR : S_IGNORE;
                    end
                    S_MADDR:
                    begin
                        maddr <= {rx_byte[7:1], 1'b0};
                        crc4  <= crc4_next;
                        state <= crc_mode ? S_LEN : S_DATA;
                    end
                    S_LEN:
                    begin
                        len   <= rx_byte[7:4];
                        state <= len_ok ? S_DATA : S_IGNORE;
                    end
                    S_DATA:
                    begin
                        if (crc_byte)
                        begin
                            word_pend <= (rx_byte == crc8);
                            state     <= S_IGNORE;
                        end
                        else
                        begin
                            crc8 <= crc8_next;
                            dcnt <= dcnt + 3'd1;
                            if (dcnt[0])
                            begin
                                word <= {rx_byte, lo_byte};
                                word_addr <= maddr;
                                maddr <= maddr + 8'd2;
                                word_pend <= ~crc_mode;
                            end
                            else
                                lo_byte <= rx_byte;                  // low byte first
                        end
                    end
                    default: state <= S_IGNORE;
                endcase
            end
            // pull sda low for the ack slot on the falling edge
            if (scl_fall & ack_phase & (bitcnt == 4'h0))
            begin
                o_sda_oe <= ~o_sda_oe & (state != S_IGNORE);
                if (o_sda_oe)
                    ack_phase <= 1'b0;
                else if (state == S_IGNORE)
                    ack_phase <= 1'b0;
            end
        end
    end

    // a protected frame carries its word until the crc8 is seen; the
    // single word kept here is why protected frames commit only their last word
    wire wr_cmd    = word_pend & (word_addr == sensor_regs_pkg::ADDR_CMD);
    wire wr_status = word_pend & (word_addr == sensor_regs_pkg::ADDR_STATUS);
    wire do_sleep  = wr_cmd & (word == sensor_regs_pkg::CMD_SLEEP);
    wire do_reset  = wr_cmd & (word == sensor_regs_pkg::CMD_RESET);
    wire res_ok    = i_crc_ok & ~o_reload;
    wire t_load    = i_temp_load & res_ok;
    wire p_load    = i_pres_load & res_ok;
    wire [15:0] clr = wr_status ? (word & sensor_regs_pkg::EVENT_MASK) : 16'h0000;

    // status: set wins over a clear in the same cycle
    logic [15:0] set_bits;
    always_comb
    begin
        set_bits = 16'h0000;
        set_bits[sensor_regs_pkg::BIT_T_UP]     = t_load;
        set_bits[sensor_regs_pkg::BIT_S_UP]     = p_load;
        set_bits[sensor_regs_pkg::BIT_T_MISSED] = t_load & o_status[sensor_regs_pkg::BIT_T_UP];
        set_bits[sensor_regs_pkg::BIT_S_MISSED] = p_load & o_status[sensor_regs_pkg::BIT_S_UP];
        set_bits[sensor_regs_pkg::BIT_CRC_ERR]  = ev_crc;
    end
    wire [15:0] next_status = ((o_status & ~clr) | set_bits) & sensor_regs_pkg::EVENT_MASK;

    // device state, results and status
    logic [4:0] reload_cnt;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_sleep         <= 1'b0;
            o_reload        <= 1'b1;
            reload_cnt      <= 5'd0;
            o_results_valid <= 1'b0;
            o_temp          <= 16'h0000;
            o_pres          <= 16'h0000;
            o_status        <= sensor_regs_pkg::STATUS_RESET;
        end
        else
        begin
            o_status <= next_status | {15'h0000, i_idle};
            if (do_sleep)
                o_sleep <= 1'b1;
            if (do_reset)
            begin
                o_sleep         <= 1'b0;
                o_reload        <= 1'b1;
                reload_cnt      <= 5'd0;
                o_results_valid <= 1'b0;
                o_status        <= sensor_regs_pkg::STATUS_RESET;
            end
            else if (o_reload)
            begin
                if (reload_cnt != 5'(sensor_regs_pkg::RELOAD_CYCLES))
                    reload_cnt <= reload_cnt + 5'd1;
                else if (i_reload_done)
                    o_reload <= 1'b0;
            end
            // other command values fall through untouched
            if (t_load)
                o_temp <= i_temp_value;
            if (p_load)
                o_pres <= i_pres_value;
            if ((t_load | o_status[sensor_regs_pkg::BIT_T_UP])
                & (p_load | o_status[sensor_regs_pkg::BIT_S_UP]) & ~do_reset)
                o_results_valid <= 1'b1;
        end
    end

    // checks
    flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        t_load && !do_reset |=> o_status[sensor_regs_pkg::BIT_T_UP])
        else $error("temp flag not set");
    pres_flag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        p_load && !do_reset
        |=> o_status[sensor_regs_pkg::BIT_S_UP] && o_pres == $past(i_pres_value))
        else $error("pres flag or value wrong");
    sleep_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        do_sleep && !do_reset |=> o_sleep) else $error("sleep not entered");
    reset_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        do_reset |=> (o_reload && !o_results_valid) [*2]) else $error("reset not run");
    crc_block_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_crc_ok |=> $stable(o_temp) && $stable(o_pres)) else $error("result changed");
    other_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_cmd && !do_sleep && !do_reset && !o_reload |=> $stable(o_sleep) && !o_reload)
        else $error("stray command acted");
    flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_status[sensor_regs_pkg::BIT_CRC_ERR] && !wr_status && !do_reset
        |=> o_status[sensor_regs_pkg::BIT_CRC_ERR]) else $error("flag dropped");
    status_clr_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_status && word[sensor_regs_pkg::BIT_CRC_ERR] && !ev_crc && !do_reset
        |=> !o_status[sensor_regs_pkg::BIT_CRC_ERR]) else $error("flag not cleared");
    ro_protect_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        word_pend && !i_temp_load && word_addr == sensor_regs_pkg::ADDR_TEMP
        |=> $stable(o_temp)) else $error("result written");
endmodule
`default_nettype wire

//--- bench/i2c_master_model.sv
// i2c bus master model that sends write frames to the sensor slave
`default_nettype none
module i2c_master_model (
    // pacing clock
    input  wire logic i_clk,
    // bus pins, sda open drain
    output logic      o_scl,
    output logic      o_sda_oe,
    input  wire logic i_sda,
    // every byte of the last frame was acknowledged
    output logic      o_all_acked
);
    timeunit 1ns;
    timeprecision 1ns;

    // clock stands still high and sda is released between frames
    initial
    begin
        o_scl       = 1'b1;
        o_sda_oe    = 1'b0;
        o_all_acked = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // eight bits msb first, then sda released for the acknowledge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--)
        begin
            o_sda_oe = (i > 0) && !b[i-1];
            wait_clk(2);
            o_scl = 1'b1;
            wait_clk(4); // high phase; slave samples through its synchroniser
            if (i == 0 && i_sda !== 1'b0)
                o_all_acked = 1'b0;
            o_scl = 1'b0;
            wait_clk(2);
        end
    endtask

    // start, bytes in the order given, stop; 8 system clocks per bit
    task automatic write_frame(input logic [7:0] bytes[$]);
        o_all_acked = 1'b1;
        o_sda_oe    = 1'b1; // start: sda falls while scl is high
        wait_clk(4);
        o_scl = 1'b0;
        wait_clk(2);
        foreach (bytes[k])
            send_byte(bytes[k]);
        o_sda_oe = 1'b1;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(4);
        o_sda_oe = 1'b0; // stop: sda rises while scl is high
        wait_clk(8);
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the sensor command and result register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_clk  = 1'b0;
    logic        i_rstn = 1'b0;
    logic        temp_load = 1'b0, pres_load = 1'b0, crc_ok = 1'b1;
    logic        reload_done = 1'b0, idle = 1'b1;
    logic [15:0] temp_value = 16'h0000, pres_value = 16'h0000;
    logic        scl, m_oe, d_oe, acked, sleep, reload, valid;
    logic [15:0] temp, pres, status;
    wire         sda;
    int          errors = 0;
    int          num_checks = 0;

    // open drain data line with pull-up
    assign sda = (m_oe | d_oe) ? 1'b0 : 1'b1;

    always #10 i_clk = ~i_clk;

    sensor_command_result_regs dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_oe(d_oe),
        .i_temp_load(temp_load), .i_temp_value(temp_value), .i_pres_load(pres_load),
        .i_pres_value(pres_value), .i_crc_ok(crc_ok), .i_reload_done(reload_done),
        .i_idle(idle), .o_sleep(sleep), .o_reload(reload), .o_results_valid(valid),
        .o_temp(temp), .o_pres(pres), .o_status(status)
    );

    i2c_master_model m (
        .i_clk(i_clk), .o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda), .o_all_acked(acked)
    );

    task automatic complete_run;
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string s);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string s);
        check_word({15'h0000, got}, {15'h0000, exp}, s);
    endtask

    // one-cycle load pulse, then three idle cycles so the flags settle before the caller looks
    task automatic load(input logic is_temp, input logic [15:0] v);
        @(negedge i_clk);
        temp_value = v;
        pres_value = v;
        temp_load  = is_temp;
        pres_load  = !is_temp;
        @(negedge i_clk);
        temp_load = 1'b0;
        pres_load = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask

    task automatic wait_reload(output int n);
        n = 0;
        while (reload === 1'b1 && n < 200)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask

    task automatic t_reset;
        int n;
        repeat (6) @(negedge i_clk);
        check_bit(reload, 1'b1, "reload in reset");
        check_word(status, 16'h0000, "status in reset");
        i_rstn      = 1'b1;
        reload_done = 1'b1;
        wait_reload(n);
        check_bit(n >= sensor_regs_pkg::RELOAD_CYCLES && n < 200, 1'b1, "reload span");
    endtask

    task automatic t_results;
        load(1'b1, 16'h7DF2);
        check_word(temp, 16'h7DF2, "temperature");
        check_bit(valid, 1'b0, "valid early");
        load(1'b0, 16'h82EA);
        check_word(pres, 16'h82EA, "pressure");
        check_bit(valid, 1'b1, "valid");
        load(1'b0, 16'h82EB);
        check_word(status, 16'h4019, "flags after loads");
    endtask

    task automatic t_protect;
        m.write_frame('{8'hD8, 8'h2E, 8'h34, 8'h12});
        check_bit(acked, 1'b1, "plain frame ack");
        check_word(temp, 16'h7DF2, "protected result");
        m.write_frame('{8'hD8, 8'h36, 8'h00, 8'h00});
        check_word(status, 16'h4019, "zero write keeps flags");
    endtask

    task automatic t_crc_frames;
        m.write_frame('{8'hDA, 8'h36, 8'h16, 8'h9E, 8'hCF, 8'h0F});
        check_word(status, 16'h4819, "bad check byte");
        m.write_frame('{8'hDA, 8'h36, 8'h16, 8'h9E, 8'hCF, 8'h0E});
        check_word(status, 16'h0001, "protected clear");
        // 0x17 would only pass if the device byte were wrongly fed into crc4
        m.write_frame('{8'hDA, 8'h36, 8'h17, 8'h9E, 8'hCF, 8'h0E});
        check_word(status, 16'h0801, "bad crc4 flagged, word dropped");
    endtask

    task automatic t_commands;
        int n;
        m.write_frame('{8'hD8, 8'h22, 8'h34, 8'h12});
        check_bit(sleep | reload, 1'b0, "other command");
        m.write_frame('{8'hD8, 8'h22, 8'h6C, 8'h32});
        check_bit(sleep, 1'b0, "swapped bytes");
        m.write_frame('{8'hD0, 8'h22, 8'h32, 8'h6C});
        check_bit(acked, 1'b0, "foreign address nack");
        check_bit(sleep, 1'b0, "foreign address");
        m.write_frame('{8'hD8, 8'h22, 8'h32, 8'h6C});
        check_bit(sleep, 1'b1, "sleep");
        reload_done = 1'b0;
        m.write_frame('{8'hD8, 8'h22, 8'h69, 8'hB1});
        check_bit(reload, 1'b1, "reload started");
        check_bit(sleep, 1'b0, "sleep left");
        crc_ok      = 1'b0;
        reload_done = 1'b1;
        wait_reload(n);
        check_bit(reload, 1'b0, "reload finished");
        m.write_frame('{8'hD8, 8'h36, 8'hFF, 8'hFF});
        load(1'b1, 16'h1111);
        load(1'b0, 16'h2222);
        check_word(status, 16'h0001, "no flags after bad memory");
        check_bit(temp === 16'h1111 || pres === 16'h2222, 1'b0, "results frozen");
    endtask

    // watchdog: whole sequence needs well under 10000 cycles
    initial
    begin
        repeat (40000) @(posedge i_clk);
        errors++;
        complete_run;
    end

    initial
    begin
        t_reset;
        t_results;
        t_protect;
        t_crc_frames;
        t_commands;
        complete_run;
    end
endmodule
`default_nettype wire
